// >>> design/lbd_pkg.sv
`default_nettype none
package lbd_pkg;
  // ---------------------------------------------------------------
  // ownership status values
  // ---------------------------------------------------------------
  localparam logic [7:0] OWN_READY   = 8'hFF;  // assembled, not yet sent
  localparam logic [7:0] OWN_OPENED  = 8'h00;  // device has begun sending
  // ---------------------------------------------------------------
  // transmit descriptor byte offsets (8-byte entry)
  // ---------------------------------------------------------------
  localparam logic [2:0] DSC_COL     = 3'h0;
  localparam logic [2:0] DSC_STAT    = 3'h1;
  localparam logic [2:0] DSC_START_L = 3'h2;
  localparam logic [2:0] DSC_START_H = 3'h3;
  localparam logic [2:0] DSC_LEN_L   = 3'h4;
  localparam logic [2:0] DSC_LEN_H   = 3'h5;
  localparam logic [2:0] DSC_CFG     = 3'h6;
  localparam logic [15:0] DSC_SIZE   = 16'h0008;
  // ---------------------------------------------------------------
  // receive packet header layout (page offset 00h onward)
  // ---------------------------------------------------------------
  localparam logic [7:0]  HDR_STAT   = 8'h00;
  localparam logic [7:0]  HDR_NEXT   = 8'h01;
  localparam logic [7:0]  HDR_CNT_L  = 8'h02;
  localparam logic [7:0]  HDR_CNT_H  = 8'h03;
  localparam logic [7:0]  HDR_BYTES  = 8'h04;
  localparam logic [7:0]  PAGE_LAST  = 8'hFF;
  // ---------------------------------------------------------------
  // enhancement register field and reset values
  // ---------------------------------------------------------------
  localparam int          ENH_QMODE_BIT = 5;  // 1 selects linked-list receive
  localparam logic [15:0] TAB_RESET     = 16'h0000;
  localparam logic [7:0]  PAGE_RESET    = 8'h00;
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } lbd_mem_req_t;
  typedef struct packed {
    logic [15:0] start;
    logic [15:0] len;
    logic [7:0]  cfg;
  } lbd_tx_job_t;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_RD   = 3'b001,
    TX_OPEN = 3'b010,
    TX_WAIT = 3'b011,
    TX_WCOL = 3'b100,
    TX_WST  = 3'b101
  } lbd_tx_state_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_WR   = 3'b001,
    RX_HDR  = 3'b010,
    RX_DROP = 3'b011,
    RX_NEXT = 3'b100
  } lbd_rx_state_t;
endpackage : lbd_pkg
`default_nettype wire

// >>> design/lbd_dma.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - non-FF entry after last frame ends queue
// - go command accepted anytime, new frame sent
// - queue end raises complete; appended portion again
// - unopened descriptors keep FF status
// - descriptor byte layout, lanes little-endian
// - collision count written back per frame
// - status 00 open, mid done, FF ready
// - start bytes form one 16-bit pointer
// - length bytes give bytes to send
// - config byte loaded per frame, unused ignored
// - enhancement bit selects receive buffering scheme; when set, receive is only held idle
// - packets stored in ring of 256-byte pages
// - start page first, end page excluded
// - packet uses consecutive pages, 4-byte header
// - header: status, next page, count lo/hi
// - data then four CRC bytes in order
// - end page wraps to ring first page
// - boundary page open aborts, sets both flags
// - FF read, body read, 00 written, status later
module lbd_dma (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // command and configuration
  input  wire logic                 transmit_go_cmd,
  input  wire logic                 halt_cmd_bit,
  input  wire logic [7:0]           enhancement_reg,
  input  wire logic [7:0]           tx_tab_begin,
  input  wire logic [7:0]           tx_tab_end,
  input  wire logic                 tx_tab_load,
  input  wire logic [15:0]          tx_tab_init,
  input  wire logic [7:0]           ring_first_page,
  input  wire logic [7:0]           ring_end_page,
  input  wire logic [7:0]           boundary_page,
  input  wire logic                 ring_write_load,
  input  wire logic [7:0]           ring_write_init,
  input  wire logic                 flags_clr,
  // transmit memory port
  output lbd_pkg::lbd_mem_req_t     tx_mem_o,
  input  wire logic                 tx_mem_ack,
  input  wire logic [7:0]           tx_mem_rdata,
  // transmit engine handshake
  output lbd_pkg::lbd_tx_job_t      tx_job_o,
  output logic                      tx_start_o,
  input  wire logic                 tx_done,
  input  wire logic                 tx_abort,
  input  wire logic [7:0]           tx_status,
  input  wire logic [7:0]           tx_collisions,
  // transmit status
  output logic                      tx_complete_o,
  output logic                      tx_halted_o,
  output logic [15:0]               tx_tab_ptr_o,
  // receive byte stream
  input  wire logic                 rx_valid,
  input  wire logic [7:0]           rx_data,
  input  wire logic                 rx_last,
  input  wire logic [7:0]           rx_status,
  output logic                      rx_ready_o,
  // receive memory port
  output lbd_pkg::lbd_mem_req_t     rx_mem_o,
  input  wire logic                 rx_mem_ack,
  // receive status
  output logic [7:0]                ring_write_page_o,
  output logic                      rx_frame_done_o,
  output logic                      overwrite_flag_o,
  output logic                      missed_packet_bit_o
);
  import lbd_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // page after p, folding the excluded end page back to the first
  function automatic logic [7:0] ring_next(input logic [7:0] p,
                                           input logic [7:0] first,
                                           input logic [7:0] stop);
    logic [7:0] n;
    n = p + 8'h01;
    ring_next = (n == stop) ? first : n;
  endfunction

  // descriptor entry after e, wrapping the table at its end page
  function automatic logic [15:0] tab_next(input logic [15:0] e,
                                           input logic [7:0] first,
                                           input logic [7:0] stop);
    logic [15:0] n;
    n = e + DSC_SIZE;
    tab_next = (n[15:8] == stop) ? {first, 8'h00} : n;
  endfunction

  // ---------------------------------------------------------------
  // transmit queue walker
  // ---------------------------------------------------------------
  lbd_tx_state_t tx_state_q;
  logic [2:0]    tx_idx_q;
  logic          go_pend_q;
  logic          tx_end_q;      // finished frame closes the chain
  logic [7:0]    tx_stat_q;

  // go request is remembered until the walker is idle and not halted; a new go in the
  // same cycle as the clear wins, so an appended frame is never lost
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      go_pend_q <= 1'b0;
    end else if (transmit_go_cmd) begin
      go_pend_q <= 1'b1;
    end else if (tx_state_q == TX_IDLE && !halt_cmd_bit) begin
      go_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_state_q    <= TX_IDLE;
      tx_idx_q      <= DSC_STAT;
      tx_mem_o      <= '0;
      tx_job_o      <= '0;
      tx_start_o    <= 1'b0;
      tx_complete_o <= 1'b0;
      tx_halted_o   <= 1'b0;
      tx_tab_ptr_o  <= TAB_RESET;
      tx_end_q      <= 1'b0;
      tx_stat_q     <= 8'h00;
    end else begin
      tx_start_o    <= 1'b0;
      tx_complete_o <= 1'b0;
      case (tx_state_q)
        TX_IDLE: begin
          tx_halted_o <= halt_cmd_bit;
          if (tx_tab_load) begin
            tx_tab_ptr_o <= tx_tab_init;
          end else if (go_pend_q && !halt_cmd_bit) begin
            tx_idx_q   <= DSC_STAT; // status is checked first
            tx_state_q <= TX_RD;
          end
        end
        TX_RD: begin
          if (!tx_mem_o.req) begin
            tx_mem_o <= '{req: 1'b1, we: 1'b0, addr: tx_tab_ptr_o + {13'h0, tx_idx_q}, wdata: 8'h00};
          end else if (tx_mem_ack) begin
            tx_mem_o.req <= 1'b0;
            case (tx_idx_q)
              DSC_STAT: begin
                if (tx_mem_rdata != OWN_READY) begin
                  // queue end: entry left untouched, chain reported done
                  tx_complete_o <= 1'b1;
                  tx_state_q    <= TX_IDLE;
                end else begin
                  tx_idx_q <= DSC_START_L;
                end
              end
              DSC_START_L: tx_job_o.start[7:0]  <= tx_mem_rdata;
              DSC_START_H: tx_job_o.start[15:8] <= tx_mem_rdata;
              DSC_LEN_L:   tx_job_o.len[7:0]    <= tx_mem_rdata;
              DSC_LEN_H:   tx_job_o.len[15:8]   <= tx_mem_rdata;
              DSC_CFG:     tx_job_o.cfg         <= tx_mem_rdata;
              default:     tx_job_o             <= tx_job_o;
            endcase
            // the unused byte after config is never fetched
            if (tx_idx_q == DSC_CFG) begin
              tx_state_q <= TX_OPEN;
            end else if (tx_idx_q != DSC_STAT) begin
              tx_idx_q <= tx_idx_q + 3'h1;
            end
          end
        end
        TX_OPEN: begin
          // mark opened only once the whole entry is in hand
          if (!tx_mem_o.req) begin
            tx_mem_o <= '{req: 1'b1, we: 1'b1, addr: tx_tab_ptr_o + {13'h0, DSC_STAT}, wdata: OWN_OPENED};
          end else if (tx_mem_ack) begin
            tx_mem_o.req <= 1'b0;
            tx_start_o   <= 1'b1;
            tx_state_q   <= TX_WAIT;
          end
        end
        TX_WAIT: begin
          if (tx_done) begin
            tx_stat_q  <= tx_status;
            tx_end_q   <= tx_abort || halt_cmd_bit;
            tx_mem_o   <= '{req: 1'b1, we: 1'b1, addr: tx_tab_ptr_o + {13'h0, DSC_COL}, wdata: tx_collisions};
            tx_state_q <= TX_WCOL;
          end
        end
        TX_WCOL: begin
          if (tx_mem_ack) begin
            tx_mem_o   <= '{req: 1'b1, we: 1'b1, addr: tx_tab_ptr_o + {13'h0, DSC_STAT}, wdata: tx_stat_q};
            tx_state_q <= TX_WST;
          end
        end
        TX_WST: begin
          if (tx_mem_ack) begin
            tx_mem_o.req <= 1'b0;
            // pointer moves on so a halt leaves it at the first unsent entry
            tx_tab_ptr_o <= tab_next(tx_tab_ptr_o, tx_tab_begin, tx_tab_end);
            tx_idx_q     <= DSC_STAT;
            if (tx_end_q) begin
              tx_complete_o <= 1'b1;
              tx_state_q    <= TX_IDLE;
            end else begin
              tx_state_q <= TX_RD;
            end
          end
        end
        default: tx_state_q <= TX_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // receive ring store
  // ---------------------------------------------------------------
  lbd_rx_state_t rx_state_q;
  logic [7:0]    rx_page_q;     // page being written
  logic [7:0]    rx_off_q;      // next offset within that page
  logic [15:0]   rx_cnt_q;      // header plus data plus CRC bytes
  logic [7:0]    rx_stat_q;
  logic [7:0]    rx_nextp_q;
  logic [1:0]    rx_hidx_q;
  logic          ring_mode;
  logic          rx_take;

  assign ring_mode = !enhancement_reg[ENH_QMODE_BIT];
  assign rx_take   = rx_valid && rx_ready_o;

  // byte of the header selected by index
  function automatic logic [7:0] hdr_byte(input logic [1:0] i, input logic [7:0] st,
                                          input logic [7:0] nx, input logic [15:0] cnt);
    case (i)
      2'h0:    hdr_byte = st;
      2'h1:    hdr_byte = nx;
      2'h2:    hdr_byte = cnt[7:0];
      default: hdr_byte = cnt[15:8];
    endcase
  endfunction

  // flags: hardware set wins over a clear in the same cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      overwrite_flag_o    <= 1'b0;
      missed_packet_bit_o <= 1'b0;
    end else if (rx_state_q == RX_WR && rx_take && rx_off_q == 8'h00
                 && rx_page_q == boundary_page) begin
      overwrite_flag_o    <= 1'b1;
      missed_packet_bit_o <= 1'b1;
    end else if (flags_clr) begin
      overwrite_flag_o    <= 1'b0;
      missed_packet_bit_o <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_state_q        <= RX_IDLE;
      rx_page_q         <= PAGE_RESET;
      rx_off_q          <= 8'h00;
      rx_cnt_q          <= 16'h0000;
      rx_stat_q         <= 8'h00;
      rx_nextp_q        <= PAGE_RESET;
      rx_hidx_q         <= 2'h0;
      rx_ready_o        <= 1'b0;
      rx_mem_o          <= '0;
      ring_write_page_o <= PAGE_RESET;
      rx_frame_done_o   <= 1'b0;
    end else begin
      rx_frame_done_o <= 1'b0;
      case (rx_state_q)
        RX_IDLE: begin
          rx_ready_o <= 1'b0;
          if (ring_write_load) begin
            ring_write_page_o <= ring_write_init;
          end else if (ring_mode) begin
            // data starts past the header in the current page
            rx_page_q  <= ring_write_page_o;
            rx_off_q   <= HDR_BYTES;
            rx_cnt_q   <= {8'h00, HDR_BYTES};
            rx_ready_o <= 1'b1;
            rx_state_q <= RX_WR;
          end
        end
        RX_WR: begin
          if (rx_take) begin
            rx_ready_o <= 1'b0;
            if (rx_last) begin
              rx_stat_q <= rx_status;
            end
            if (rx_off_q == 8'h00 && rx_page_q == boundary_page) begin
              // protected page stays unwritten; rest of frame is dropped
              rx_ready_o <= !rx_last;
              rx_state_q <= rx_last ? RX_IDLE : RX_DROP;
            end else begin
              rx_mem_o <= '{req: 1'b1, we: 1'b1, addr: {rx_page_q, rx_off_q}, wdata: rx_data};
              rx_cnt_q <= rx_cnt_q + 16'h0001;
              rx_hidx_q <= rx_last ? 2'h3 : 2'h0; // marks the final byte
            end
          end else if (rx_mem_o.req && rx_mem_ack) begin
            rx_mem_o.req <= 1'b0;
            rx_off_q     <= rx_off_q + 8'h01;
            if (rx_off_q == PAGE_LAST) begin
              rx_page_q <= ring_next(rx_page_q, ring_first_page, ring_end_page);
            end
            if (rx_hidx_q == 2'h3) begin
              rx_state_q <= RX_NEXT;
            end else begin
              rx_ready_o <= 1'b1;
            end
          end
        end
        RX_NEXT: begin
          // a page only partly filled still counts as used
          rx_nextp_q <= (rx_off_q == 8'h00) ? rx_page_q
                        : ring_next(rx_page_q, ring_first_page, ring_end_page);
          rx_hidx_q  <= 2'h0;
          rx_state_q <= RX_HDR;
        end
        RX_HDR: begin
          if (!rx_mem_o.req) begin
            rx_mem_o <= '{req: 1'b1, we: 1'b1, addr: {ring_write_page_o, 6'h00, rx_hidx_q},
                          wdata: hdr_byte(rx_hidx_q, rx_stat_q, rx_nextp_q, rx_cnt_q)};
          end else if (rx_mem_ack) begin
            rx_mem_o.req <= 1'b0;
            rx_hidx_q    <= rx_hidx_q + 2'h1;
            if (rx_hidx_q == 2'h3) begin
              // header last, so software never sees a half-stored packet
              ring_write_page_o <= rx_nextp_q;
              rx_frame_done_o   <= 1'b1;
              rx_state_q        <= RX_IDLE;
            end
          end
        end
        RX_DROP: begin
          if (rx_valid && rx_last) begin
            rx_ready_o <= 1'b0;
            rx_state_q <= RX_IDLE;
          end
        end
        default: rx_state_q <= RX_IDLE;
      endcase
    end
  end

endmodule // lbd_dma
`default_nettype wire

// >>> dv/lbd_dma_props.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// port checker
// ---------------------------------------------------------------
module lbd_dma_props
  import lbd_pkg::*;
(
  // clock and reset
  input wire logic                  sys_clk,
  input wire logic                  rst,
  // configuration
  input wire logic [7:0]            enhancement_reg,
  input wire logic [7:0]            tx_tab_begin,
  input wire logic [7:0]            tx_tab_end,
  input wire logic                  tx_tab_load,
  input wire logic [7:0]            ring_first_page,
  input wire logic [7:0]            ring_end_page,
  input wire logic [7:0]            boundary_page,
  input wire logic                  flags_clr,
  // memory ports and status
  input wire lbd_pkg::lbd_mem_req_t tx_mem_o,
  input wire logic                  tx_mem_ack,
  input wire logic                  tx_start_o,
  input wire logic [15:0]           tx_tab_ptr_o,
  input wire logic                  rx_ready_o,
  input wire lbd_pkg::lbd_mem_req_t rx_mem_o,
  input wire logic                  rx_mem_ack,
  input wire logic                  overwrite_flag_o,
  input wire logic                  missed_packet_bit_o
);
  import lbd_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // a request may not move before its answer, or memory sees a torn access
  property p_tx_hold; tx_mem_o.req && !tx_mem_ack |=> tx_mem_o.req && $stable(tx_mem_o); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx request moved before ack");
  property p_rx_hold; rx_mem_o.req && !rx_mem_ack |=> rx_mem_o.req && $stable(rx_mem_o); endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx request moved before ack");
  // descriptor traffic stays inside the table
  property p_tx_table; tx_mem_o.req |-> tx_mem_o.addr[15:8] >= tx_tab_begin && tx_mem_o.addr[15:8] < tx_tab_end;
  endproperty
  a_tx_table: assert property (p_tx_table) else $error("tx access outside table");
  // the frame is handed on only once the opened mark is stored
  property p_open_start;
    tx_mem_ack && tx_mem_o.we && tx_mem_o.wdata == OWN_OPENED && tx_mem_o.addr[2:0] == DSC_STAT |-> ##[1:2] tx_start_o;
  endproperty
  a_open_start: assert property (p_open_start) else $error("no start after open mark");
  property p_start_pulse; tx_start_o |=> !tx_start_o; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");
  property p_ptr_step;
    !$stable(tx_tab_ptr_o) && !$past(tx_tab_load) |-> tx_tab_ptr_o == $past(tx_tab_ptr_o) + DSC_SIZE
      || tx_tab_ptr_o == {tx_tab_begin, 8'h00};
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("table pointer bad step");
  property p_ring; rx_mem_o.req |-> rx_mem_o.addr[15:8] >= ring_first_page && rx_mem_o.addr[15:8] < ring_end_page;
  endproperty
  a_ring: assert property (p_ring) else $error("rx write outside ring");
  property p_bound; rx_mem_o.req |-> rx_mem_o.addr[15:8] != boundary_page; endproperty
  a_bound: assert property (p_bound) else $error("protected page written");
  property p_sticky; overwrite_flag_o && !flags_clr |=> overwrite_flag_o && missed_packet_bit_o; endproperty
  a_sticky: assert property (p_sticky) else $error("overwrite flags lost");
  property p_list_mode; enhancement_reg[ENH_QMODE_BIT] [*3] |-> !rx_ready_o; endproperty
  a_list_mode: assert property (p_list_mode) else $error("ring open in list mode");
endmodule // lbd_dma_props
bind lbd_dma lbd_dma_props u_props (.*);
`default_nettype wire

// >>> dv/lbd_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// shared buffer memory
// ---------------------------------------------------------------
module lbd_mem_model
  import lbd_pkg::*;
(
  // clock and answer delay
  input  wire logic                  sys_clk,
  input  wire logic [1:0]            wait_cycles,
  // transmit side
  input  wire lbd_pkg::lbd_mem_req_t tx_req,
  output logic                       tx_ack,
  output logic [7:0]                 tx_rdata,
  // receive side
  input  wire lbd_pkg::lbd_mem_req_t rx_req,
  output logic                       rx_ack
);
  import lbd_pkg::*;
  logic [7:0] mem [0:65535];
  int         tcnt;
  int         rcnt;
  // read data flips outside an answer so a stale byte never looks right
  initial begin
    tx_ack = 1'b0;
    rx_ack = 1'b0;
    tx_rdata = 8'h5A;
    forever begin
      @(posedge sys_clk);
      #1;
      tx_rdata = ~tx_rdata;
      if (tx_ack || !tx_req.req) begin
        tx_ack = 1'b0;
        tcnt = 0;
      end else if (tcnt < wait_cycles) tcnt++;
      else begin
        tx_ack = 1'b1;
        if (tx_req.we) mem[tx_req.addr] = tx_req.wdata;
        else tx_rdata = mem[tx_req.addr];
      end
      if (rx_ack || !rx_req.req) begin
        rx_ack = 1'b0;
        rcnt = 0;
      end else if (rcnt < wait_cycles) rcnt++;
      else begin
        rx_ack = 1'b1;
        if (rx_req.we) mem[rx_req.addr] = rx_req.wdata;
      end
    end
  end
endmodule // lbd_mem_model
`default_nettype wire

// >>> dv/lbd_dma_tb.sv
`timescale 1ns/1ps
`default_nettype none
module lbd_dma_tb;
  import lbd_pkg::*;
  typedef struct packed {logic [15:0] a; lbd_tx_job_t j;} lbd_tb_desc_t;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic sys_clk = 0, rst = 1, transmit_go_cmd = 0, halt_cmd_bit = 0, tx_tab_load = 0, ring_write_load = 0;
  logic flags_clr = 0, tx_mem_ack, rx_mem_ack, tx_done = 0, tx_abort = 0, rx_valid = 0, rx_last = 0;
  logic [7:0] enhancement_reg = 0, tx_tab_begin = 8'h10, tx_tab_end = 8'h11, ring_first_page = 8'h40;
  logic [7:0] ring_end_page = 8'h43, boundary_page = 8'h20, ring_write_init = 8'h42, tx_mem_rdata;
  logic [7:0] tx_status = 0, tx_collisions = 0, rx_data = 0, rx_status = 0, ring_write_page_o, cur_wp, keep;
  logic [15:0] tx_tab_init = 16'h10F0, tx_tab_ptr_o, tail;
  logic [1:0] wait_cycles = 0;
  logic tx_start_o, tx_complete_o, tx_halted_o, rx_ready_o, rx_frame_done_o, overwrite_flag_o;
  logic missed_packet_bit_o, halt_next = 0;
  lbd_mem_req_t tx_mem_o, rx_mem_o;
  lbd_tx_job_t tx_job_o, jobs[$];
  lbd_tb_desc_t pend[$];
  logic [7:0] sts[$], cols[$];
  int bad_count = 0, n_compared = 0, n_cmpl = 0, seed = 32'hbc1edeca;
  lbd_dma uut (.*);
  lbd_mem_model mem_u (.sys_clk(sys_clk), .wait_cycles(wait_cycles), .tx_req(tx_mem_o), .tx_ack(tx_mem_ack),
    .tx_rdata(tx_mem_rdata), .rx_req(rx_mem_o), .rx_ack(rx_mem_ack));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  function automatic logic [15:0] nxt(input logic [15:0] t);
    return (t[15:8] + ((t[7:0] + 8) >> 8)) == tx_tab_end ? {tx_tab_begin, 8'h00} : t + DSC_SIZE;
  endfunction
  function automatic logic [7:0] pg(input int k);
    return 8'(ring_first_page + (cur_wp - ring_first_page + k) % (ring_end_page - ring_first_page));
  endfunction
  // driver: body first under a private mark, stop entry next, ready mark last
  task automatic add_desc();
    lbd_tb_desc_t d;
    d.a = tail;
    d.j = {16'($random(seed)), 16'(($random(seed) & 32'h7FF) + 18), 8'($random(seed))};
    mem_u.mem[tail + 1] = 8'h33;
    {mem_u.mem[tail + 3], mem_u.mem[tail + 2], mem_u.mem[tail + 5], mem_u.mem[tail + 4]} = d.j[39:8];
    mem_u.mem[tail + 6] = d.j.cfg;
    mem_u.mem[tail + 7] = 8'($random(seed));
    tail = nxt(tail);
    mem_u.mem[tail + 1] = 8'h5A;
    mem_u.mem[d.a + 1] = OWN_READY;
    pend.push_back(d);
  endtask
  task automatic run_go(input int nf);
    int c0, w;
    lbd_tb_desc_t d;
    c0 = n_cmpl;
    transmit_go_cmd = 1;
    @(posedge sys_clk); #1 transmit_go_cmd = 0;
    for (w = 0; w < 3000 && n_cmpl == c0; w++) @(posedge sys_clk);
    repeat (40) @(posedge sys_clk);
    #1 check(16'(n_cmpl - c0), 1, "complete pulses");
    check(16'(jobs.size()), 16'(nf), "frames started");
    while (jobs.size() > 0) begin
      d = pend.pop_front();
      check(jobs[0].start, d.j.start, "start pointer");
      check(jobs[0].len, d.j.len, "length");
      check(jobs[0].cfg, d.j.cfg, "config");
      check(mem_u.mem[d.a], cols.pop_front(), "collision tally");
      check(mem_u.mem[d.a + 1], sts.pop_front(), "status written back");
      void'(jobs.pop_front());
    end
    d.a = pend.size() > 0 ? pend[0].a : tail;
    check(tx_tab_ptr_o, d.a, "table pointer");
    check(mem_u.mem[d.a + 1], pend.size() > 0 ? OWN_READY : 8'h5A, "entry left alone");
    $display("test tx %0d frames done", nf);
  endtask
  task automatic rx_send(input int n, input logic ovf);
    int i, w;
    logic [7:0] q[$];
    logic [15:0] off;
    rx_status = 8'($random(seed));
    for (i = 0; i < n; i++) begin
      q.push_back(8'($random(seed)));
      rx_valid = 1;
      rx_data = q[i];
      rx_last = (i == n - 1);
      do @(negedge sys_clk); while (rx_ready_o !== 1'b1);
      @(posedge sys_clk); #1;
    end
    rx_valid = 0;
    rx_last = 0;
    for (w = 0; w < 2000 && !ovf && rx_frame_done_o !== 1'b1; w++) begin @(posedge sys_clk); #1; end
    repeat (20) @(posedge sys_clk);
    #1 check(ring_write_page_o, ovf ? cur_wp : pg(((n + 3) >> 8) + 1), "write page");
    if (ovf) begin
      check({overwrite_flag_o, missed_packet_bit_o}, 2'b11, "overflow flags");
      check(mem_u.mem[{boundary_page, 8'h00}], keep, "protected page");
    end else begin
      check(16'(w < 2000), 1, "frame done");
      for (i = 0; i < n; i++) begin
        off = 16'(4 + i);
        check(mem_u.mem[{pg(off >> 8), off[7:0]}], q[i], "stored byte");
      end
      check(mem_u.mem[{cur_wp, HDR_STAT}], rx_status, "header status");
      check(mem_u.mem[{cur_wp, HDR_NEXT}], pg(((n + 3) >> 8) + 1), "header next");
      check({mem_u.mem[{cur_wp, HDR_CNT_H}], mem_u.mem[{cur_wp, HDR_CNT_L}]}, 16'(n + 4), "count");
      cur_wp = pg(((n + 3) >> 8) + 1);
    end
    $display("test rx %0d bytes done", n);
  endtask
  // ---------------------------------------------------------------
  // clock, transmit engine, watchdog, sequence
  // ---------------------------------------------------------------
  initial forever #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) #1 if (tx_complete_o === 1'b1) n_cmpl++;
  // engine: finishes each started frame; may raise halt mid frame
  initial forever begin
    @(posedge sys_clk); #1;
    if (tx_start_o === 1'b1) begin
      jobs.push_back(tx_job_o);
      if (halt_next) halt_cmd_bit = 1;
      repeat (3) @(posedge sys_clk);
      #1 tx_done = 1;
      tx_status = 8'(($random(seed) & 32'h7F) + 1);
      tx_collisions = 8'($random(seed) & 32'hF);
      sts.push_back(tx_status);
      cols.push_back(tx_collisions);
      @(posedge sys_clk); #1 tx_done = 0;
    end
  end
  initial begin
    repeat (40000) @(posedge sys_clk);
    $display("ERROR %0t watchdog expired", $time);
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    #1 rst = 0;
    enhancement_reg = 8'h20;
    // both loads are taken only while their walker is idle: list mode keeps receive idle
    tail = tx_tab_init;
    mem_u.mem[tail + 1] = 8'h5A;
    {tx_tab_load, ring_write_load} = 2'b11;
    cur_wp = ring_write_init;
    @(posedge sys_clk); #1 {tx_tab_load, ring_write_load} = 0;
    repeat (5) @(posedge sys_clk);
    #1 check(rx_ready_o, 0, "ready in list mode");
    enhancement_reg = 8'h00;
    repeat (4) @(posedge sys_clk);
    #1 check(rx_ready_o, 1, "ready in ring mode");
    $display("test mode done");
    repeat (3) add_desc();
    run_go(3);
    wait_cycles = 2;
    add_desc();
    run_go(1);
    halt_next = 1;
    repeat (2) add_desc();
    run_go(1);
    check(tx_halted_o, 1, "halted");
    halt_next = 0;
    halt_cmd_bit = 0;
    run_go(1);
    rx_send(300, 0);
    rx_send(10 + ($random(seed) & 31), 0);
    boundary_page = 8'h40;
    keep = mem_u.mem[16'h4000];
    rx_send(300, 1);
    flags_clr = 1;
    @(posedge sys_clk); #1 flags_clr = 0;
    repeat (2) @(posedge sys_clk);
    #1 check({overwrite_flag_o, missed_packet_bit_o}, 0, "flags cleared");
    complete_run();
  end
endmodule // lbd_dma_tb
`default_nettype wire
